// ==== rtl/banked_sfr_select.sv ====
/*
 * Bank selection, core registers, banked peripheral window and banked
 * general purpose RAM of an 8-bit core's data memory.
 * Assumes the core drives one request per cycle, synchronous to mclk_i,
 * and keeps the arithmetic flags itself.
 */
//
// What this block does
// - bank select byte fully readable and writable
// - low nibble picks peripheral bank
// - high nibble picks RAM bank
// - special registers sit in data memory
// - only 10h to 17h are peripheral banked
// - unimplemented bank reads all zero
// - unimplemented bank drops writes, flags unaffected
// - one instruction loads peripheral bank
// - one instruction loads RAM bank
// - latch holds program counter bits 15:8
// - upper counter byte reached only via latch
// - master clear keeps timeout, powerdown flags
// - unimplemented register bits read zero
`timescale 1ns/10ps
`include "banked_sfr_select_consts.svh"

module banked_sfr_select #(
    parameter int PERIPH_BANKS = 9,
    parameter int RAM_BANKS = 4
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic master_clear_reset_i,
    input wire logic ce_i,
    input wire banked_sfr_select_pkg::core_req_s req_i,
    input wire banked_sfr_select_pkg::bank_instr_s instr_i,
    input wire logic pc_sync_i,
    input wire logic [15:0] pc_value_i,
    input wire logic wdt_timeout_i,
    input wire logic sleep_i,
    output logic [7:0] rd_data_o,
    output logic write_dropped_o,
    output logic [7:0] pc_high_o,
    output logic [7:0] pc_low_o,
    output logic [3:0] periph_bank_o,
    output logic [3:0] ram_bank_o
);
    import banked_sfr_select_pkg::*;

    localparam int GPR_WORDS = 224;

    // plain storage for implemented peripheral banks and RAM banks
    logic [7:0] periph_mem [PERIPH_BANKS*8];
    logic [7:0] gpr_mem [RAM_BANKS*GPR_WORDS];

    logic [7:0] bank_select;
    logic [7:0] indirect_pointer_0;
    logic [7:0] indirect_pointer_1;
    logic [7:0] program_counter_low;
    logic [7:0] program_counter_high_latch;
    logic [7:0] pc_high;
    logic timeout_flag;
    logic powerdown_flag;

    function automatic region_e region_of(input logic [7:0] a);
        if (a <= `CORE_LAST) begin
            return REGION_CORE;
        end else if (a >= `WINDOW_FIRST && a <= `WINDOW_LAST) begin
            return REGION_BANKED;
        end else if (a >= `GPR_FIRST) begin
            return REGION_GPR;
        end else begin
            return REGION_NONE;
        end
    endfunction : region_of

    // indirect ports substitute their pointer as the address
    function automatic logic [7:0] eff_addr(input logic [7:0] a,
                                            input logic [7:0] p0,
                                            input logic [7:0] p1);
        if (a == `OFS_INDIRECT_PORT_0) begin
            return p0;
        end else if (a == `OFS_INDIRECT_PORT_1) begin
            return p1;
        end else begin
            return a;
        end
    endfunction : eff_addr

    wire logic [7:0] ea = eff_addr(req_i.addr, indirect_pointer_0,
                                   indirect_pointer_1);
    wire region_e region = region_of(ea);
    wire logic [3:0] pbank = bank_select[3:0];
    wire logic [3:0] rbank = bank_select[7:4];
    wire logic pbank_ok = 32'(pbank) < PERIPH_BANKS;
    wire logic rbank_ok = 32'(rbank) < RAM_BANKS;
    wire logic [2:0] win_ofs = ea[2:0];
    wire logic [7:0] gpr_ofs = ea - `GPR_FIRST;
    // nets must be four-state, so the indices are plain 32-bit vectors
    wire logic [31:0] periph_idx = 32'(pbank) * 32'd8 + 32'(win_ofs);
    wire logic [31:0] gpr_idx = 32'(rbank) * 32'(GPR_WORDS) + 32'(gpr_ofs);

    // a pointer aimed at an indirect port yields nothing
    wire logic self_ref = region == REGION_CORE
        && (ea == `OFS_INDIRECT_PORT_0 || ea == `OFS_INDIRECT_PORT_1);

    wire logic hit_bsr = region == REGION_CORE && ea == `OFS_BANK_SELECT;
    wire logic hit_ptr0 = region == REGION_CORE && ea == `OFS_INDIRECT_PTR_0;
    wire logic hit_ptr1 = region == REGION_CORE && ea == `OFS_INDIRECT_PTR_1;
    wire logic hit_pcl = region == REGION_CORE && ea == `OFS_PC_LOW;
    wire logic hit_latch = region == REGION_CORE
        && ea == `OFS_PC_HIGH_LATCH;
    wire logic hit_status = region == REGION_CORE && ea == `OFS_CPU_STATUS;

    wire logic periph_live = region == REGION_BANKED && pbank_ok;
    wire logic gpr_live = region == REGION_GPR && rbank_ok;
    wire logic unimpl_bank = (region == REGION_BANKED && !pbank_ok)
        || (region == REGION_GPR && !rbank_ok);

    wire logic wr = ce_i && req_i.wr && !self_ref;
    wire logic rd = ce_i && req_i.rd;

    // status packs only the two flags kept here; other bits read zero
    wire logic [7:0] status_view = {4'h0, timeout_flag, powerdown_flag,
                                    2'h0};

    logic [7:0] next_rd_data;
    always_comb begin
        next_rd_data = 8'h00;
        case (region)
            REGION_CORE: begin
                if (hit_bsr) begin
                    next_rd_data = bank_select;
                end else if (hit_ptr0) begin
                    next_rd_data = indirect_pointer_0;
                end else if (hit_ptr1) begin
                    next_rd_data = indirect_pointer_1;
                end else if (hit_pcl) begin
                    next_rd_data = program_counter_low;
                end else if (hit_latch) begin
                    next_rd_data = program_counter_high_latch;
                end else if (hit_status) begin
                    next_rd_data = status_view;
                end
            end
            REGION_BANKED: begin
                if (pbank_ok) begin
                    next_rd_data = periph_mem[periph_idx];
                end
            end
            REGION_GPR: begin
                if (rbank_ok) begin
                    next_rd_data = gpr_mem[gpr_idx];
                end
            end
            default: begin
                next_rd_data = 8'h00;
            end
        endcase
    end

    // instructions win over a same-cycle bus write to the select byte
    wire logic [7:0] bsr_after_bus = (wr && hit_bsr) ? req_i.wdata
                                                     : bank_select;
    wire logic [7:0] next_bank_select = {
        instr_i.load_rbank ? instr_i.literal : bsr_after_bus[7:4],
        instr_i.load_pbank ? instr_i.literal : bsr_after_bus[3:0]
    };

    wire logic any_rst = sys_rst_i || master_clear_reset_i;

    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            bank_select <= `RST_BANK_SELECT;
        end else if (ce_i) begin
            bank_select <= next_bank_select;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            indirect_pointer_0 <= `RST_POINTER;
            indirect_pointer_1 <= `RST_POINTER;
        end else if (wr) begin
            if (hit_ptr0) begin
                indirect_pointer_0 <= req_i.wdata;
            end
            if (hit_ptr1) begin
                indirect_pointer_1 <= req_i.wdata;
            end
        end
    end

    // writing the low byte moves the latch into the hidden upper byte
    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            program_counter_low <= `RST_PC_LOW;
            program_counter_high_latch <= `RST_PC_HIGH_LATCH;
            pc_high <= `RST_PC_HIGH_LATCH;
        end else if (ce_i) begin
            if (pc_sync_i) begin
                program_counter_low <= pc_value_i[7:0];
                pc_high <= pc_value_i[15:8];
                program_counter_high_latch <= pc_value_i[15:8];
            end else begin
                if (wr && hit_pcl) begin
                    program_counter_low <= req_i.wdata;
                    pc_high <= program_counter_high_latch;
                end
                if (wr && hit_latch) begin
                    program_counter_high_latch <= req_i.wdata;
                end
            end
        end
    end

    // only a power-on reset sets the flags; master clear leaves them
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (ce_i && !master_clear_reset_i) begin
            if (wdt_timeout_i) begin
                timeout_flag <= 1'b0;
            end
            if (sleep_i) begin
                powerdown_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (wr && !any_rst && periph_live) begin
            periph_mem[periph_idx] <= req_i.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (wr && !any_rst && gpr_live) begin
            gpr_mem[gpr_idx] <= req_i.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            rd_data_o <= 8'h00;
            write_dropped_o <= 1'b0;
        end else if (ce_i) begin
            rd_data_o <= rd ? next_rd_data : 8'h00;
            write_dropped_o <= wr && unimpl_bank;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            pc_high_o <= `RST_PC_HIGH_LATCH;
            pc_low_o <= `RST_PC_LOW;
            periph_bank_o <= 4'h0;
            ram_bank_o <= 4'h0;
        end else if (ce_i) begin
            pc_high_o <= pc_high;
            pc_low_o <= program_counter_low;
            periph_bank_o <= next_bank_select[3:0];
            ram_bank_o <= next_bank_select[7:4];
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i || master_clear_reset_i);

    a_bsr_write_holds: assert property (
        ce_i && wr && hit_bsr && !instr_i.load_pbank && !instr_i.load_rbank
        |=> bank_select == $past(req_i.wdata))
        else $error("bank select write lost");

    a_pbank_instr_load: assert property (
        ce_i && instr_i.load_pbank
        |=> bank_select[3:0] == $past(instr_i.literal)
            && periph_bank_o == bank_select[3:0])
        else $error("peripheral bank load failed");

    a_rbank_instr_load: assert property (
        ce_i && instr_i.load_rbank && !instr_i.load_pbank
        |=> ram_bank_o == $past(instr_i.literal)
            && bank_select[3:0] == $past(bsr_after_bus[3:0]))
        else $error("ram bank load failed");

    a_unimpl_read_zero: assert property (
        rd && unimpl_bank |=> rd_data_o == 8'h00)
        else $error("unimplemented bank read not zero");

    a_unimpl_write_flag: assert property (
        ce_i && wr && unimpl_bank |=> write_dropped_o)
        else $error("dropped write not flagged");

    a_window_only_banked: assert property (
        rd && ea > `WINDOW_LAST && ea < `GPR_FIRST |=> rd_data_o == 8'h00)
        else $error("gap above window answered a read");

    a_core_read_bsr: assert property (
        rd && hit_bsr |=> rd_data_o == $past(bank_select))
        else $error("core register read depends on bank");

    a_status_zero_bits: assert property (
        rd && hit_status |=> rd_data_o[7:4] == 4'h0
            && rd_data_o[1:0] == 2'h0)
        else $error("status reserved bits not zero");

    // a stalled cycle holds the output copy back
    a_pcl_write_moves: assert property (
        ce_i && wr && hit_pcl && !pc_sync_i
        |=> pc_high == $past(program_counter_high_latch)
            ##1 (!$past(ce_i) || pc_high_o == $past(pc_high)))
        else $error("latch not moved into counter");

    a_master_clear_reset_keeps_flags: assert property (
        @(posedge mclk_i) disable iff (sys_rst_i)
        master_clear_reset_i |=> timeout_flag == $past(timeout_flag)
            && powerdown_flag == $past(powerdown_flag))
        else $error("master clear changed flags");

    a_reset_clears_bsr: assert property (
        @(posedge mclk_i) disable iff (1'b0)
        sys_rst_i || master_clear_reset_i |=> bank_select == 8'h00)
        else $error("reset left bank select set");

    // a latch write alone must not reach the hidden upper byte
    a_latch_write_stays: assert property (
        ce_i && wr && hit_latch && !pc_sync_i
        |=> pc_high == $past(pc_high))
        else $error("latch write moved upper byte");

    a_sync_loads_latch: assert property (
        ce_i && pc_sync_i
        |=> program_counter_high_latch == $past(pc_value_i[15:8])
            && pc_high == $past(pc_value_i[15:8]))
        else $error("jump did not load latch");

    a_stall_holds_bsr: assert property (
        !ce_i |=> bank_select == $past(bank_select))
        else $error("bank select changed while stalled");

endmodule : banked_sfr_select

// ==== rtl/banked_sfr_select_consts.svh ====
/*
 * Register offsets, field positions, window bounds and reset values of
 * the banked register select block.
 * Assumes 8-bit data addresses driven by the processor core.
 */
`ifndef BANKED_SFR_SELECT_CONSTS_SVH
`define BANKED_SFR_SELECT_CONSTS_SVH

`define OFS_INDIRECT_PORT_0 8'h00
`define OFS_INDIRECT_PTR_0 8'h01
`define OFS_PC_LOW 8'h02
`define OFS_PC_HIGH_LATCH 8'h03
`define OFS_CPU_STATUS 8'h06
`define OFS_INDIRECT_PORT_1 8'h08
`define OFS_INDIRECT_PTR_1 8'h09
`define OFS_BANK_SELECT 8'h0f

`define CORE_LAST 8'h0f
`define WINDOW_FIRST 8'h10
`define WINDOW_LAST 8'h17
`define GPR_FIRST 8'h20

`define STATUS_TIMEOUT_BIT 3
`define STATUS_POWERDOWN_BIT 2

`define RST_BANK_SELECT 8'h00
`define RST_PC_LOW 8'h00
`define RST_PC_HIGH_LATCH 8'h00
`define RST_POINTER 8'h00

`endif

// ==== rtl/banked_sfr_select_pkg.sv ====
/*
 * Types shared by the banked register select block.
 * Assumes the consts header is included by the design file.
 */
package banked_sfr_select_pkg;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } core_req_s;

    typedef struct packed {
        logic load_pbank;
        logic load_rbank;
        logic [3:0] literal;
    } bank_instr_s;

    typedef enum logic [1:0] {
        REGION_CORE,
        REGION_BANKED,
        REGION_GPR,
        REGION_NONE
    } region_e;

endpackage : banked_sfr_select_pkg

// ==== dv/core_driver.sv ====
/* Stand-in for the processor core: drives bus requests and bank instructions.
   Assumes callers step it once per clock, 1 ns after the rising edge. */
`timescale 1ns/10ps
module core_driver (
    input wire logic mclk_i,
    output banked_sfr_select_pkg::core_req_s req_o,
    output banked_sfr_select_pkg::bank_instr_s instr_o
);
    import banked_sfr_select_pkg::*;
    initial begin
        req_o = '0;
        instr_o = '0;
    end
    // held for one edge; the next step replaces it
    task automatic op(input logic rd, input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        instr_o = '0;
        req_o = '{rd: rd, wr: wr, addr: a, wdata: d};
    endtask : op
    // reserved bank contents are never trusted by this core
    task automatic ld(input logic p, input logic r, input logic [3:0] v);
        @(posedge mclk_i);
        #1;
        req_o = '0;
        instr_o = '{load_pbank: p, load_rbank: r, literal: v};
    endtask : ld
endmodule : core_driver

// ==== dv/banked_sfr_select_test.sv ====
/* Self-checking bench for the banked register select block.
   Assumes the design's default bank counts: 9 peripheral, 4 RAM banks. */
`timescale 1ns/10ps
`include "banked_sfr_select_consts.svh"
module banked_sfr_select_test;
    import banked_sfr_select_pkg::*;
    localparam int PB = 9;
    localparam int RB = 4;
    localparam logic [7:0] ST_PD = 8'h01 << `STATUS_POWERDOWN_BIT;
    localparam logic [7:0] ST_ALL = ST_PD | (8'h01 << `STATUS_TIMEOUT_BIT);
    logic mclk_i = 0, sys_rst_i = 1, master_clear_reset_i = 0, ce_i = 1, pc_sync_i = 0;
    logic wdt_timeout_i = 0, sleep_i = 0, pend = 0, write_dropped_o;
    logic [15:0] pc_value_i = '0, pv;
    core_req_s req_i;
    bank_instr_s instr_i;
    logic [7:0] rd_data_o, pc_high_o, pc_low_o, v, w;
    logic [3:0] periph_bank_o, ram_bank_o;
    logic [7:0] q[$];
    int fail_count = 0, n_checks = 0;

    banked_sfr_select dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .master_clear_reset_i(master_clear_reset_i),
        .ce_i(ce_i), .req_i(req_i), .instr_i(instr_i), .pc_sync_i(pc_sync_i),
        .pc_value_i(pc_value_i), .wdt_timeout_i(wdt_timeout_i), .sleep_i(sleep_i),
        .rd_data_o(rd_data_o), .write_dropped_o(write_dropped_o),
        .pc_high_o(pc_high_o), .pc_low_o(pc_low_o),
        .periph_bank_o(periph_bank_o), .ram_bank_o(ram_bank_o));
    core_driver drv (.mclk_i(mclk_i), .req_o(req_i), .instr_o(instr_i));

    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) pend <= ce_i & req_i.rd & ~sys_rst_i & ~master_clear_reset_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        drv.op(1, 0, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        drv.op(0, 1, a, d);
    endtask : wr
    task automatic idle;
        drv.op(0, 0, 8'h00, 8'h00);
    endtask : idle
    task automatic step;
        @(posedge mclk_i);
        #1;
    endtask : step
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // read data lands on the same edge that takes the read
    always @(posedge mclk_i) begin
        #2;
        if (pend) begin
            if (q.size() == 0) chk(rd_data_o, 8'hxx);
            else chk(rd_data_o, q.pop_front());
        end
    end

    initial begin
        #(40 * 3000);
        fail_count++;
        give_verdict;
    end

    initial begin
        void'($urandom(32'he7c820f9));
        repeat (2) @(posedge mclk_i);
        #1;
        sys_rst_i = 0;
        rd(`OFS_BANK_SELECT, `RST_BANK_SELECT);
        rd(`OFS_PC_HIGH_LATCH, `RST_PC_HIGH_LATCH);
        rd(`OFS_CPU_STATUS, ST_ALL);
        rd(8'h05, 8'h00);
        v = 8'($urandom);
        w = 8'($urandom);
        wr(`OFS_BANK_SELECT, v);
        rd(`OFS_BANK_SELECT, v);
        idle;
        chk({4'h0, periph_bank_o}, {4'h0, v[3:0]});
        chk({4'h0, ram_bank_o}, {4'h0, v[7:4]});
        wr(`OFS_PC_HIGH_LATCH, w);
        drv.ld(1, 1, ~v[3:0]);
        rd(`OFS_PC_HIGH_LATCH, w);
        wr(8'h18, 8'hff);
        rd(8'h18, 8'h00);
        // banks 0 and 8 share 10h: separation shows up there
        for (int b = 0; b < 16; b++) begin
            drv.ld(1, 0, 4'(b));
            wr(8'h10 + 8'(b % 8), 8'(b) ^ 8'ha5);
            idle;
            chk({7'h0, write_dropped_o}, {7'h0, b >= PB});
        end
        for (int b = 0; b < 15; b++) begin
            drv.ld(1, 0, 4'(b));
            rd(8'h10 + 8'(b % 8), b < PB ? 8'(b) ^ 8'ha5 : 8'h00);
        end
        for (int r = 0; r < 6; r++) begin
            drv.ld(0, 1, 4'(r));
            wr(8'hff, 8'(r) + 8'h3c);
        end
        for (int r = 0; r < 6; r++) begin
            drv.ld(0, 1, 4'(r));
            rd(8'hff, r < RB ? 8'(r) + 8'h3c : 8'h00);
        end
        drv.ld(1, 1, 4'h2);
        idle;
        chk({periph_bank_o, ram_bank_o}, 8'h22);
        ce_i = 0;
        wr(`OFS_BANK_SELECT, 8'h77);
        idle;
        ce_i = 1;
        rd(`OFS_BANK_SELECT, 8'h22);
        wr(`OFS_INDIRECT_PTR_1, 8'h40);
        wr(`OFS_INDIRECT_PORT_1, v);
        rd(8'h40, v);
        wr(`OFS_INDIRECT_PTR_0, 8'h41);
        wr(`OFS_INDIRECT_PORT_0, w);
        rd(8'h41, w);
        rd(`OFS_INDIRECT_PORT_0, w);
        // a pointer aimed at the other port reaches nothing
        wr(`OFS_INDIRECT_PTR_0, `OFS_INDIRECT_PORT_1);
        wr(`OFS_INDIRECT_PORT_0, 8'h5a);
        rd(`OFS_INDIRECT_PORT_0, 8'h00);
        rd(8'h40, v);
        wr(`OFS_PC_HIGH_LATCH, w);
        wr(`OFS_PC_LOW, v);
        idle;
        // both output copies trail the internal counter by one edge
        step;
        chk(pc_low_o, v);
        step;
        chk(pc_high_o, w);
        pv = 16'($urandom);
        pc_sync_i = 1;
        pc_value_i = pv;
        step;
        pc_sync_i = 0;
        rd(`OFS_PC_HIGH_LATCH, pv[15:8]);
        wr(`OFS_PC_HIGH_LATCH, ~pv[15:8]);
        idle;
        repeat (2) step;
        chk(pc_high_o, pv[15:8]);
        chk(pc_low_o, pv[7:0]);
        wdt_timeout_i = 1;
        step;
        wdt_timeout_i = 0;
        rd(`OFS_CPU_STATUS, ST_PD);
        idle;
        master_clear_reset_i = 1;
        step;
        master_clear_reset_i = 0;
        rd(`OFS_CPU_STATUS, ST_PD);
        rd(`OFS_BANK_SELECT, `RST_BANK_SELECT);
        idle;
        sleep_i = 1;
        step;
        sleep_i = 0;
        rd(`OFS_CPU_STATUS, 8'h00);
        idle;
        repeat (2) step;
        give_verdict;
    end
endmodule : banked_sfr_select_test
